// file: hw/tfhr_pkg.sv
package tfhr_pkg;

   // Raw host-side pins, as they arrive from the cable
   typedef struct packed {
      logic cs0_n;
      logic cs1_n;
      logic [2:0] da;
      logic dior_n;
      logic diow_n;
      logic dmack_n;
      logic [15:0] dd;
   } tfhr_pins_t;

   // Cylinder parameter pair handed to the command engine
   typedef struct packed {
      logic [7:0] track_upper_param;
      logic [7:0] track_lower_param;
   } tfhr_params_t;

   // Decoded register target of the current host access
   typedef enum logic [2:0] {
      TGT_NONE = 3'h0,
      TGT_DATA = 3'h1,
      TGT_LOW = 3'h2,
      TGT_HIGH = 3'h3,
      TGT_CMD = 3'h4,
      TGT_CTRL = 3'h5,
      TGT_DMA = 3'h6
   } tfhr_target_t;

   // Register addresses on the DA lines
   localparam logic [2:0] DA_DATA = 3'h0;
   localparam logic [2:0] DA_LOW = 3'h4;
   localparam logic [2:0] DA_HIGH = 3'h5;
   localparam logic [2:0] DA_CMD = 3'h7;
   localparam logic [2:0] DA_CTRL = 3'h6;

   // Control register field positions and reset value
   localparam int CTRL_SRST_BIT = 2;
   localparam int CTRL_NIEN_BIT = 1;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] CTRL_WR_MASK = 8'h06;
   localparam logic [7:0] PARAM_RESET = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h00;

   // Data path sizes
   localparam int WORD_W = 16;
   localparam int FIFO_DEPTH_DEF = 8;

endpackage

// file: hw/tfhr_fifo.sv
`timescale 1ns/100ps
// Small FIFO holding host write words until the core drains them
module tfhr_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH]; // Storage, no reset needed
   logic [AW-1:0] wr_ptr; // Next slot to fill
   logic [AW-1:0] rd_ptr; // Next slot to drain
   logic [AW:0] count; // Occupancy, one bit wider than pointers
   logic push;
   logic pop;

   // Handshakes; full and empty come from the true count
   assign in_ready = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem[rd_ptr];

   // Pointer and count update
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push)
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   // Storage write
   always_ff @(posedge sys_clk) begin
      if (push)
         mem[wr_ptr] <= in_data;
   end

endmodule

// file: hw/tfhr_port.sv
`timescale 1ns/100ps
// How it works
// - Control-block write at alt address hits control
// - Alternate status mirrors primary status exactly
// - Alternate status read keeps pending interrupt
// - Command address reads return primary status
// - Command write starts command only when selected, captures parameters
// - Command write clears pending interrupt
// - Command code is eight bits wide
// - Cylinder registers read/write, valid when not busy
// - PIO and DMA data are 16 bits
// - PIO accesses walk sequential words
// - DMA accesses walk sequential words
// - Control write takes effect immediately
// - Control layout: SRST bit 2, nIEN bit 1
// - INTRQ driven only when enabled and selected
// - SRST triggers software reset
// - Invalid selects release data bus, ignore strobes
// - DEV bit picks device zero or one
// - Primary status read clears pending interrupt
// - SRST resets both devices regardless of selection
module tfhr_port #(
   parameter logic DEV_ID = 1'b0,
   parameter int FIFO_DEPTH = tfhr_pkg::FIFO_DEPTH_DEF
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire tfhr_pkg::tfhr_pins_t pins,
   input wire logic dev_bit,
   input wire logic [7:0] core_status,
   input wire logic cmd_done,
   input wire logic xfer_out,
   input wire logic dma_active,
   input wire logic [tfhr_pkg::WORD_W-1:0] rd_word,
   input wire logic result_load,
   input wire tfhr_pkg::tfhr_params_t result_params,
   input wire logic wr_ready,
   output logic [tfhr_pkg::WORD_W-1:0] dd_out,
   output logic dd_oe,
   output logic dmarq,
   output logic intrq,
   output logic intrq_oe,
   output logic srst,
   output logic cmd_start,
   output logic [7:0] cmd_code,
   output tfhr_pkg::tfhr_params_t cmd_params,
   output logic rd_take,
   output logic wr_valid,
   output logic [tfhr_pkg::WORD_W-1:0] wr_word
);
   import tfhr_pkg::*;

   // Pin synchronisers; stage one is read by stage two only
   tfhr_pins_t pin_s1;
   tfhr_pins_t pin_s2;
   logic rd_prev; // Accepted read (read_ok) one sample ago
   logic wr_prev; // Write strobe one sample ago
   tfhr_target_t wr_tgt; // Target seen during the write strobe
   logic [WORD_W-1:0] wr_data; // Last data seen during the strobe

   // Register state
   logic [7:0] ctrl; // Host control bits
   logic [7:0] status; // One status copy serves both views
   tfhr_params_t params; // Cylinder pair
   logic pending; // Pending interrupt condition
   logic push; // One-cycle FIFO write
   logic [WORD_W-1:0] push_data;
   logic fifo_in_ready;

   // Decode nets
   logic cs0;
   logic cs1;
   logic dmack;
   logic selected;
   tfhr_target_t cmd_tgt;
   tfhr_target_t tgt;
   logic rd_lvl;
   logic wr_lvl;
   logic read_ok;
   logic rd_rise;
   logic wr_end;
   logic [WORD_W-1:0] read_val;
   logic is_data_rd;
   logic stat_clear;
   logic cmd_wr;
   logic ctrl_wr;
   logic data_wr;
   logic next_pending;

   // Two flip-flops on every pin before any logic looks
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         pin_s1 <= '1;
         pin_s2 <= '1;
      end else begin
         pin_s1 <= pins;
         pin_s2 <= pin_s1;
      end
   end

   // Pins are active low on the cable
   assign cs0 = ~pin_s2.cs0_n;
   assign cs1 = ~pin_s2.cs1_n;
   assign dmack = ~pin_s2.dmack_n;
   assign selected = (dev_bit == DEV_ID);

   // Command block register decode
   assign cmd_tgt = (pin_s2.da == DA_DATA) ? TGT_DATA :
                    (pin_s2.da == DA_LOW) ? TGT_LOW :
                    (pin_s2.da == DA_HIGH) ? TGT_HIGH :
                    (pin_s2.da == DA_CMD) ? TGT_CMD : TGT_NONE;

   // Both selects equal is invalid, except a DMA burst
   assign tgt = (cs0 & ~cs1) ? cmd_tgt :
                (cs1 & ~cs0 & pin_s2.da == DA_CTRL) ? TGT_CTRL :
                (~cs0 & ~cs1 & dmack) ? TGT_DMA : TGT_NONE;

   assign rd_lvl = ~pin_s2.dior_n;
   assign wr_lvl = ~pin_s2.diow_n;

   // Only the selected device answers register reads
   assign read_ok = rd_lvl & (tgt != TGT_NONE) &
                    ((tgt == TGT_DMA) ? dma_active : selected);
   assign rd_rise = read_ok & ~rd_prev;
   assign wr_end = wr_prev & ~wr_lvl;

   // Read mux; both status views share one register
   always_comb begin
      read_val = '0;
      unique case (tgt)
         TGT_DATA, TGT_DMA: read_val = rd_word;
         TGT_LOW: read_val = {8'h00, params.track_lower_param};
         TGT_HIGH: read_val = {8'h00, params.track_upper_param};
         TGT_CMD: read_val = {8'h00, status};
         TGT_CTRL: read_val = {8'h00, status};
         TGT_NONE: read_val = '0;
         default: read_val = '0;
      endcase
   end

   // Data reads advance the word stream, only in out direction
   assign is_data_rd = ((tgt == TGT_DATA) | (tgt == TGT_DMA)) & xfer_out;
   // Only the primary status read clears; alternate does not
   assign stat_clear = rd_rise & (tgt == TGT_CMD);

   // Write effects land at the end of the strobe
   assign cmd_wr = wr_end & (wr_tgt == TGT_CMD);
   assign ctrl_wr = wr_end & (wr_tgt == TGT_CTRL);
   // Wrong-direction data writes are dropped
   assign data_wr = wr_end & ~xfer_out &
                    ((wr_tgt == TGT_DATA) |
                     ((wr_tgt == TGT_DMA) & dma_active));

   // Completion wins over a clear in the same cycle
   assign next_pending = cmd_done ? 1'b1 :
                         (srst | cmd_wr | stat_clear) ? 1'b0 :
                         pending;

   // Strobe history and write capture
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         rd_prev <= 1'b0;
         wr_prev <= 1'b0;
         wr_tgt <= TGT_NONE;
         wr_data <= '0;
      end else begin
         rd_prev <= read_ok;
         wr_prev <= wr_lvl;
         if (wr_lvl) begin
            wr_tgt <= tgt;
            wr_data <= pin_s2.dd;
         end
      end
   end

   // Bus drive: latch word on read start, release otherwise
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         dd_out <= '0;
         dd_oe <= 1'b0;
         rd_take <= 1'b0;
      end else begin
         dd_oe <= read_ok;
         rd_take <= rd_rise & is_data_rd;
         if (rd_rise)
            dd_out <= read_val;
      end
   end

   // Control register applies on the write itself
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset)
         ctrl <= CTRL_RESET;
      else if (ctrl_wr)
         ctrl <= wr_data[7:0] & CTRL_WR_MASK;
   end

   // Status snapshot and cylinder registers
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         status <= STATUS_RESET;
         params <= {PARAM_RESET, PARAM_RESET};
      end else begin
         status <= core_status;
         if (wr_end & (wr_tgt == TGT_LOW))
            params.track_lower_param <= wr_data[7:0];
         else if (wr_end & (wr_tgt == TGT_HIGH))
            params.track_upper_param <= wr_data[7:0];
         else if (result_load)
            params <= result_params;
      end
   end

   // Command launch; registers go to both devices, only one runs
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         cmd_start <= 1'b0;
         cmd_code <= 8'h00;
         cmd_params <= {PARAM_RESET, PARAM_RESET};
      end else begin
         cmd_start <= cmd_wr & selected;
         if (cmd_wr) begin
            cmd_code <= wr_data[7:0];
            cmd_params <= params;
         end
      end
   end

   // Interrupt flag, reset bit and tri-state gating
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         pending <= 1'b0;
         intrq <= 1'b0;
         intrq_oe <= 1'b0;
         srst <= 1'b0;
      end else begin
         pending <= next_pending;
         intrq <= pending;
         intrq_oe <= selected & ~ctrl[CTRL_NIEN_BIT];
         // Reset is honoured whatever the selection
         srst <= ctrl[CTRL_SRST_BIT];
      end
   end

   // Request DMA on out bursts, or on in bursts only while the FIFO can take a word
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         dmarq <= 1'b0;
         push <= 1'b0;
         push_data <= '0;
      end else begin
         dmarq <= dma_active & (xfer_out | fifo_in_ready);
         push <= data_wr;
         push_data <= wr_data;
      end
   end

   // A full FIFO drops DMARQ in the in direction; PIO writes past full are lost
   tfhr_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .sys_clk(sys_clk),
      .reset(reset),
      .in_valid(push),
      .in_ready(fifo_in_ready),
      .in_data(push_data),
      .out_valid(wr_valid),
      .out_ready(wr_ready),
      .out_data(wr_word)
   );

   // Checks on the host-facing behaviour
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   a_alt_keeps_int: assert property (
      rd_rise && tgt == TGT_CTRL && pending && !srst && !cmd_wr
      |=> pending) else $error("alt status read cleared interrupt");

   a_status_clears: assert property (
      stat_clear && !cmd_done |=> !pending)
      else $error("status read left interrupt pending");

   a_cmd_clears: assert property (
      cmd_wr && !cmd_done |=> !pending ##1 !intrq)
      else $error("command write left interrupt pending");

   a_cmd_launch: assert property (
      cmd_wr && selected |=> cmd_start && cmd_code == $past(wr_data[7:0])
      && cmd_params == $past(params)) else $error("command not launched");

   a_alt_mirror: assert property (
      rd_rise && tgt == TGT_CTRL |=> dd_oe && dd_out[7:0] == $past(status))
      else $error("alt status differs from status");

   a_cmd_reads_stat: assert property (
      rd_rise && tgt == TGT_CMD |=> dd_out == {8'h00, $past(status)})
      else $error("command address read not status");

   a_ctrl_apply: assert property (
      ctrl_wr |=> ##1 srst == $past(wr_data[2], 2))
      else $error("control write not applied");

   a_intrq_gate: assert property (
      ctrl_wr && wr_data[1] |=> ##1 !intrq_oe)
      else $error("interrupt driven while disabled");

   a_bus_release: assert property (
      (tgt == TGT_NONE) |=> !dd_oe) else $error("bus driven on bad address");

   c_status_read: cover property (stat_clear && pending);
   c_cmd_write: cover property (cmd_wr && selected);
   c_dma_stall: cover property (dma_active && !fifo_in_ready);
   c_srst: cover property (ctrl_wr && wr_data[2]);
   c_dma_read: cover property (rd_take && dma_active);

   // Completion must always raise the flag, even against a clear
   a_done_sets: assert property (
      cmd_done |=> pending) else $error("completion did not set interrupt");

   // Every accepted data read in the out direction takes one word from the core
   a_data_advance: assert property (
      rd_rise && is_data_rd |=> rd_take)
      else $error("data read did not advance");

   // Writes against the transfer direction never reach the FIFO
   a_wrong_dir: assert property (
      wr_end && xfer_out |=> !push)
      else $error("wrong-direction write accepted");

   // The other device owns register reads while it is selected
   a_unsel_quiet: assert property (
      !selected && tgt != TGT_DMA |=> !dd_oe)
      else $error("unselected device drove the bus");

   // A full buffer in the in direction must drop DMARQ so the host stops sending DMA words
   a_dma_full: assert property (
      !xfer_out && !fifo_in_ready |=> !dmarq)
      else $error("DMA requested into a full buffer");

endmodule

// file: tb/tfhr_host_model.sv
`timescale 1ns/100ps
// Host adapter: drives the cable pins one access at a time
module tfhr_host_model
import tfhr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic [15:0] dd_out,
   input wire logic dd_oe,
   output tfhr_pkg::tfhr_pins_t pins
);
   tfhr_pins_t hp; // Host side of the pins
   initial begin
      hp = 24'hff0000; // Selects, strobes and acknowledge all negated
   end
   // Shared DD wire: the device wins while it drives
   assign pins = {hp[23:16], dd_oe ? dd_out : hp.dd};
   // One strobe: sel is {cs0_n, cs1_n, dmack_n, da}
   // Only legal phases are issued by the bench
   // No register is trusted while the device sleeps
   task automatic acc(input logic wr, input logic [5:0] sel,
                      input logic [15:0] d, output logic [15:0] q,
                      output logic oe);
      @(posedge sys_clk);
      hp.cs0_n <= sel[5];
      hp.cs1_n <= sel[4];
      hp.dmack_n <= sel[3];
      hp.da <= sel[2:0];
      // Idle bus shows the inverse, never a stale value
      hp.dd <= wr ? d : ~hp.dd;
      hp.dior_n <= wr;
      hp.diow_n <= !wr;
      // Six clocks low, well past the two the sync needs
      repeat (6) @(posedge sys_clk);
      q = pins.dd; // Sample the shared wire, not the driver
      oe = dd_oe;
      hp.dior_n <= 1'b1;
      hp.diow_n <= 1'b1;
      repeat (6) @(posedge sys_clk);
      hp.cs0_n <= 1'b1;
      hp.cs1_n <= 1'b1;
      hp.dmack_n <= 1'b1;
      hp.dd <= ~hp.dd;
   endtask
endmodule

// file: tb/task_file_host_registers_tb.sv
`timescale 1ns/100ps
// Bench for the task-file register port
module task_file_host_registers_tb;
   import tfhr_pkg::*;
   localparam logic [5:0] S_LO = {3'b011, DA_LOW};
   localparam logic [5:0] S_HI = {3'b011, DA_HIGH};
   localparam logic [5:0] S_ST = {3'b011, DA_CMD};
   localparam logic [5:0] S_CT = {3'b101, DA_CTRL};
   localparam logic [5:0] S_DA = {3'b011, DA_DATA};
   localparam logic [5:0] S_DM = 6'b110000;
   logic sys_clk, reset, dev_bit, cmd_done, xfer_out, dma_active;
   logic wr_ready, dd_oe, dmarq, intrq, intrq_oe, srst, cmd_start;
   logic rd_take, wr_valid, oe, result_load;
   logic [7:0] core_status, cmd_code;
   logic [15:0] rd_word, dd_out, wr_word, q;
   tfhr_params_t cmd_params;
   tfhr_params_t result_params;
   tfhr_pins_t pins;
   int fail_count, num_checks, cyc, starts;
   logic [15:0] got[$]; // Words the core side took
   tfhr_host_model pm (.sys_clk(sys_clk), .dd_out(dd_out), .dd_oe(dd_oe),
      .pins(pins));
   tfhr_port dut (.sys_clk(sys_clk), .reset(reset), .pins(pins),
      .dev_bit(dev_bit), .core_status(core_status), .cmd_done(cmd_done),
      .xfer_out(xfer_out), .dma_active(dma_active), .rd_word(rd_word),
      .result_load(result_load), .result_params(result_params),
      .wr_ready(wr_ready),
      .dd_out(dd_out), .dd_oe(dd_oe), .dmarq(dmarq), .intrq(intrq),
      .intrq_oe(intrq_oe), .srst(srst), .cmd_start(cmd_start),
      .cmd_code(cmd_code), .cmd_params(cmd_params), .rd_take(rd_take),
      .wr_valid(wr_valid), .wr_word(wr_word));
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   // Core side: next read word, write sink, pulse count, hang guard
   always @(posedge sys_clk) begin
      cyc++;
      if (rd_take === 1'b1) rd_word <= rd_word + 16'h0001;
      if (wr_valid === 1'b1 && wr_ready === 1'b1) got.push_back(wr_word);
      if (cmd_start === 1'b1) starts++;
      if (cyc == 5000) begin
         fail_count++;
         conclude();
      end
   end
   task automatic conclude;
      if (fail_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] e,
                      input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [5:0] s, input logic [15:0] d);
      logic [15:0] x;
      logic y;
      pm.acc(1'b1, s, d, x, y);
   endtask
   task automatic rd(input logic [5:0] s);
      pm.acc(1'b0, s, 16'h0000, q, oe);
   endtask
   task automatic pulse_done;
      @(posedge sys_clk) cmd_done <= 1'b1;
      @(posedge sys_clk) cmd_done <= 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask
   initial begin
      reset = 1'b1;
      dev_bit = 1'b0;
      cmd_done = 1'b0;
      xfer_out = 1'b0;
      dma_active = 1'b0;
      wr_ready = 1'b1;
      result_load = 1'b0;
      result_params = 16'h0000;
      core_status = 8'h50;
      rd_word = 16'h1000;
      repeat (16) @(posedge sys_clk);
      reset <= 1'b0;
      // Cylinder pair round trip, written while idle
      wr(S_LO, 16'h005a);
      wr(S_HI, 16'h00a5);
      rd(S_LO);
      chk("cyl_low", 16'h005a, q);
      rd(S_HI);
      chk("cyl_high", 16'h00a5, q);
      // Status at both addresses
      core_status <= 8'h58;
      rd(S_ST);
      chk("status", 16'h0058, q);
      rd(S_CT);
      chk("alt_status", 16'h0058, q);
      // While busy the host trusts only the busy bit
      core_status <= 8'hd8;
      rd(S_CT);
      chk("busy_bit", 16'h0080, q & 16'h0080);
      // Idle again: commands and data need busy and request low
      core_status <= 8'h50;
      // Pending interrupt: alt read keeps it, primary read clears it
      pulse_done();
      chk("intrq_set", 16'h0001, {15'h0, intrq});
      chk("intrq_oe_on", 16'h0001, {15'h0, intrq_oe});
      rd(S_CT);
      chk("intrq_alt", 16'h0001, {15'h0, intrq});
      rd(S_ST);
      chk("intrq_st", 16'h0000, {15'h0, intrq});
      // Command write captures code and parameters, clears pending
      pulse_done();
      wr(S_ST, 16'h00ec);
      chk("starts", 16'h0001, starts[15:0]);
      chk("cmd_code", 16'h00ec, {8'h00, cmd_code});
      chk("cmd_params", 16'ha55a, cmd_params);
      chk("intrq_cmd", 16'h0000, {15'h0, intrq});
      // Result load refreshes the cylinder pair
      @(posedge sys_clk) result_params <= 16'h3cc3;
      result_load <= 1'b1;
      @(posedge sys_clk) result_load <= 1'b0;
      rd(S_LO);
      chk("res_low", 16'h00c3, q);
      rd(S_HI);
      chk("res_high", 16'h003c, q);
      // Control bits land at once
      wr(S_CT, 16'h0002);
      chk("nien_oe", 16'h0000, {15'h0, intrq_oe});
      chk("srst_off", 16'h0000, {15'h0, srst});
      wr(S_CT, 16'h0004);
      chk("srst_on", 16'h0001, {15'h0, srst});
      chk("oe_back", 16'h0001, {15'h0, intrq_oe});
      wr(S_CT, 16'h0000);
      // Other device selected: reset still applies, no start, no answer
      @(posedge sys_clk) dev_bit <= 1'b1;
      wr(S_CT, 16'h0004);
      chk("srst_other", 16'h0001, {15'h0, srst});
      chk("oe_unsel", 16'h0000, {15'h0, intrq_oe});
      wr(S_CT, 16'h0000);
      wr(S_ST, 16'h0090);
      chk("starts_unsel", 16'h0001, starts[15:0]);
      rd(S_ST);
      chk("oe_unsel_rd", 16'h0000, {15'h0, oe});
      @(posedge sys_clk) dev_bit <= 1'b0;
      // Illegal select pairs leave the bus released
      rd({3'b001, DA_CMD});
      chk("oe_both", 16'h0000, {15'h0, oe});
      rd(6'b111000);
      chk("oe_none", 16'h0000, {15'h0, oe});
      // PIO out: sequential full words
      xfer_out <= 1'b1;
      rd(S_DA);
      chk("pio_rd0", 16'h1000, q);
      rd(S_DA);
      chk("pio_rd1", 16'h1001, q);
      // PIO in
      xfer_out <= 1'b0;
      got.delete();
      wr(S_DA, 16'hbeef);
      wr(S_DA, 16'h1234);
      repeat (4) @(posedge sys_clk);
      chk("pio_cnt", 16'h0002, 16'(got.size()));
      chk("pio_wr0", 16'hbeef, got[0]);
      chk("pio_wr1", 16'h1234, got[1]);
      // DMA in with the core stalled until the buffer refuses
      got.delete();
      wr_ready <= 1'b0;
      dma_active <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk("dmarq_on", 16'h0001, {15'h0, dmarq});
      for (int i = 0; i < 8; i++) begin
         wr(S_DM, 16'h0a00 + i[15:0]);
      end
      chk("dmarq_full", 16'h0000, {15'h0, dmarq});
      wr_ready <= 1'b1;
      repeat (12) @(posedge sys_clk);
      chk("dma_cnt", 16'h0008, 16'(got.size()));
      for (int i = 0; i < 8; i++) begin
         chk("dma_wr", 16'h0a00 + i[15:0], got[i]);
      end
      chk("dmarq_drain", 16'h0001, {15'h0, dmarq});
      // DMA out continues the word sequence
      xfer_out <= 1'b1;
      rd(S_DM);
      chk("dma_rd", 16'h1002, q);
      // Burst over: request drops, idle strobes stay unanswered
      dma_active <= 1'b0;
      rd(6'b111000);
      chk("dmarq_off", 16'h0000, {15'h0, dmarq});
      chk("dma_idle", 16'h0000, {15'h0, oe});
      conclude();
   end
endmodule
